// file: common/sram_ctl_pkg.sv
package sram_ctl_pkg;
  // Pin timing, ns figures as given for the memory
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_RC_NS = 45;
  localparam int T_AA_NS = 45;
  localparam int T_HZOE_NS = 18;
  localparam int T_WC_NS = 45;
  localparam int T_PWE_NS = 35;
  localparam int T_SD_NS = 25;
  localparam int T_HZWE_NS = 18;
  localparam int T_LZWE_NS = 10;
  // Least times round up, so ceiling division
  localparam int RD_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int HZ_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SD_CYC = (T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWE_CYC = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_LOW_CYC = (HZ_CYC + SD_CYC > PWE_CYC) ? HZ_CYC + SD_CYC : PWE_CYC;
  localparam int REC_CYC = (T_LZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
endpackage : sram_ctl_pkg

// file: common/sram_pins_if.sv
`timescale 1ns/1ps
interface sram_pins_if;
  logic sel_n;
  logic we_n;
  logic oe_n;
  logic [19:0] addr;
  logic [7:0] dout;
  logic drive;
  logic [7:0] din;
  logic err;
  modport ctl (output sel_n, we_n, oe_n, addr, dout, drive, input din, err);
  modport phy (input sel_n, we_n, oe_n, addr, dout, drive, output din, err);
endinterface : sram_pins_if

// file: hw/sram_pin_sync.sv
`timescale 1ns/1ps
module sram_pin_sync
  import sram_ctl_pkg::*;
#(
  parameter int W = 9
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t st_ff;
  sync_t nxt_st;
  always_comb begin
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q_o = st_ff.s2;
endmodule : sram_pin_sync

// file: hw/sram_ctl.sv
`timescale 1ns/1ps
module sram_ctl
  import sram_ctl_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic REQ_WRITE_I,
  input wire logic [ADDR_W-1:0] REQ_ADDR_I,
  input wire logic [DATA_W-1:0] REQ_WDATA_I,
  output logic RSP_VALID_O,
  output logic [DATA_W-1:0] RSP_RDATA_O,
  output logic RSP_CORRECTED_O,
  output logic SELECT_LOW_ACTIVE_N_O,
  output logic SELECT_HIGH_ACTIVE_O,
  output logic WE_N_O,
  output logic OE_N_O,
  output logic [ADDR_W-1:0] ADDR_O,
  input wire logic [DATA_W-1:0] DATA_BUS_I,
  output logic [DATA_W-1:0] DATA_BUS_O,
  output logic DATA_BUS_OE_O,
  input wire logic ERR_I
);
  // ==========================================================
  // Pin interface and input synchroniser
  // Pins are asynchronous to MCLK_I, so only the second stage is read
  sram_pins_if pins ();
  logic [DATA_W:0] sync_q;
  sram_pin_sync #(.W(DATA_W + 1)) u_sync (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .d_i({ERR_I, DATA_BUS_I}),
    .q_o(sync_q)
  );
  assign pins.din = sync_q[DATA_W-1:0];
  assign pins.err = sync_q[DATA_W];

  // ==========================================================
  // Sequencer
  typedef enum logic [2:0] {
    S_IDLE, S_RD, S_WR_HZ, S_WR_LOW, S_WR_HOLD, S_REC
  } state_t;
  typedef struct packed {
    state_t st;
    logic [CNT_W-1:0] cnt;
    logic sel_n;
    logic we_n;
    logic oe_n;
    logic drive;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic rsp_valid;
    logic [DATA_W-1:0] rdata;
    logic corrected;
  } ctl_t;
  ctl_t r_ff;
  ctl_t nxt_r;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.rsp_valid = 1'b0;
    case (r_ff.st)
      S_IDLE: begin
        if (REQ_VALID_I) begin
          // Address set one cycle before select goes active
          nxt_r.addr = REQ_ADDR_I;
          nxt_r.wdata = REQ_WDATA_I;
          nxt_r.cnt = '0;
          if (REQ_WRITE_I) begin
            nxt_r.st = S_WR_HZ;
          end else begin
            nxt_r.st = S_RD;
          end
        end
      end
      S_RD: begin
        nxt_r.sel_n = 1'b0;
        nxt_r.oe_n = 1'b0;
        nxt_r.we_n = 1'b1;
        nxt_r.cnt = r_ff.cnt + 1'b1;
        // Two synchroniser stages delay the sampled byte
        if (r_ff.cnt == CNT_W'(RD_CYC + 2)) begin
          nxt_r.rdata = pins.din;
          nxt_r.corrected = pins.err;
          nxt_r.rsp_valid = 1'b1;
          nxt_r.sel_n = 1'b1;
          nxt_r.oe_n = 1'b1;
          nxt_r.cnt = '0;
          nxt_r.st = S_REC;
        end
      end
      S_WR_HZ: begin
        // Output gate kept high, so the bus is ours after turnaround
        nxt_r.sel_n = 1'b0;
        nxt_r.oe_n = 1'b1;
        nxt_r.cnt = r_ff.cnt + 1'b1;
        if (r_ff.cnt == CNT_W'(HZ_CYC)) begin
          nxt_r.drive = 1'b1;
          nxt_r.we_n = 1'b0;
          nxt_r.cnt = '0;
          nxt_r.st = S_WR_LOW;
        end
      end
      S_WR_LOW: begin
        nxt_r.cnt = r_ff.cnt + 1'b1;
        if (r_ff.cnt == CNT_W'(WR_LOW_CYC - 1)) begin
          // Strobe rising is the terminating edge
          nxt_r.we_n = 1'b1;
          nxt_r.cnt = '0;
          nxt_r.st = S_WR_HOLD;
        end
      end
      S_WR_HOLD: begin
        // Data and address stay one cycle past the edge
        nxt_r.drive = 1'b0;
        nxt_r.sel_n = 1'b1;
        nxt_r.st = S_REC;
      end
      S_REC: begin
        // Gap lets the memory release the bus before the next access
        nxt_r.cnt = r_ff.cnt + 1'b1;
        if (r_ff.cnt == CNT_W'(REC_CYC)) begin
          nxt_r.cnt = '0;
          nxt_r.st = S_IDLE;
        end
      end
      default: begin
        nxt_r.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      r_ff <= '{st: S_IDLE, cnt: '0, sel_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                drive: 1'b0, addr: '0, wdata: '0, rsp_valid: 1'b0,
                rdata: '0, corrected: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pins.sel_n = r_ff.sel_n;
  assign pins.we_n = r_ff.we_n;
  assign pins.oe_n = r_ff.oe_n;
  assign pins.addr = r_ff.addr;
  assign pins.dout = r_ff.wdata;
  assign pins.drive = r_ff.drive;

  assign REQ_READY_O = (r_ff.st == S_IDLE);
  assign RSP_VALID_O = r_ff.rsp_valid;
  assign RSP_RDATA_O = r_ff.rdata;
  assign RSP_CORRECTED_O = r_ff.corrected;
  // Both selects move together from one flop
  assign SELECT_LOW_ACTIVE_N_O = pins.sel_n;
  assign SELECT_HIGH_ACTIVE_O = ~pins.sel_n;
  assign WE_N_O = pins.we_n;
  assign OE_N_O = pins.oe_n;
  assign ADDR_O = pins.addr;
  assign DATA_BUS_O = pins.dout;
  assign DATA_BUS_OE_O = pins.drive;

  // ==========================================================
  // Checks
  // Data and select still stand at the strobe edge, bus released one cycle on
  sequence wr_end_s;
    r_ff.drive && !r_ff.sel_n ##1 !r_ff.drive;
  endsequence

  bus_turn_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    r_ff.drive |-> r_ff.oe_n)
    else $error("bus driven with output gate low");
  drive_sel_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    r_ff.drive |-> !r_ff.sel_n)
    else $error("bus driven while deselected");
  wr_hold_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    $rose(r_ff.we_n) |-> wr_end_s)
    else $error("write data not held past end edge");
  wr_width_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    $fell(r_ff.we_n) |-> (!r_ff.we_n && r_ff.drive) [*7])
    else $error("write strobe too short");
  addr_stable_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !r_ff.sel_n |-> $stable(r_ff.addr))
    else $error("address moved while selected");
  rd_gate_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !r_ff.oe_n |-> r_ff.we_n && !r_ff.sel_n)
    else $error("read gate without read mode");
  rd_done_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    $fell(r_ff.oe_n) |-> ##[1:14] r_ff.rsp_valid)
    else $error("read response missing");
  we_sel_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    !r_ff.we_n |-> !r_ff.sel_n && r_ff.oe_n)
    else $error("strobe low outside selected write");
  // Turnaround, read gate hold, response and idle checks
  turn_wait_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    $rose(r_ff.drive) |-> $past(r_ff.oe_n, HZ_CYC) && !$past(r_ff.sel_n, HZ_CYC))
    else $error("bus driven before turnaround wait");
  rd_hold_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    $fell(r_ff.oe_n) |-> !r_ff.oe_n [*8])
    else $error("read gate released too early");
  rsp_pulse_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    r_ff.rsp_valid |-> r_ff.sel_n && r_ff.oe_n ##1 !r_ff.rsp_valid)
    else $error("response not a single pulse after deselect");
  idle_free_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (r_ff.st == S_IDLE) |-> r_ff.sel_n && r_ff.we_n && !r_ff.drive)
    else $error("pins not released in idle");
endmodule : sram_ctl

// file: test/sram_dev_model.sv
`timescale 1ns/1ps
module sram_dev_model
  import sram_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic sel_n_i,
  input wire logic sel_h_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] bus_i,
  input wire logic flip_i,
  output logic [DATA_W-1:0] d_o,
  output logic oe_o,
  output logic err_o
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] last_ff = 8'h00;
  logic err_ff = 1'b0;
  logic armed = 1'b0;
  logic [ADDR_W-1:0] wa;
  logic sel;
  logic wr;
  assign sel = !sel_n_i && sel_h_i;
  assign wr = sel && !we_n_i;
  assign oe_o = sel && we_n_i && !oe_n_i;
  // Floating lines toggle, so a late sample never looks valid
  assign d_o = oe_o ? (mem.exists(addr_i) ? mem[addr_i] : 8'h00) : ~last_ff;
  assign err_o = oe_o ? flip_i : ~err_ff;
  // Address taken at write start; a reset abort still writes to that address at the ending edge
  always @(posedge wr) begin
    armed = 1'b1;
    wa = addr_i;
  end
  always @(negedge wr) if (armed) begin
    mem[wa] = bus_i;
    armed = 1'b0;
  end
  always @(posedge clk_i) begin
    last_ff <= d_o;
    err_ff <= err_o;
  end
endmodule : sram_dev_model

// file: test/test_async_sram_ecc_port.sv
`timescale 1ns/1ps
module test_async_sram_ecc_port;
  import sram_ctl_pkg::*;
  logic MCLK_I, RST_I, REQ_VALID_I, REQ_WRITE_I, flip;
  logic [19:0] REQ_ADDR_I, req_a, addr_q;
  logic [7:0] REQ_WDATA_I, DATA_BUS_O, dev_d, bus, wd_q;
  logic REQ_READY_O, RSP_VALID_O, RSP_CORRECTED_O, DATA_BUS_OE_O, dev_oe, err;
  logic SELECT_LOW_ACTIVE_N_O, SELECT_HIGH_ACTIVE_O, WE_N_O, OE_N_O, sel_q, wr_q;
  logic [7:0] RSP_RDATA_O;
  logic [19:0] ADDR_O;
  int failures = 0;
  int samples_checked = 0;
  wire sel = !SELECT_LOW_ACTIVE_N_O && SELECT_HIGH_ACTIVE_O;
  wire wr = sel && !WE_N_O;
  assign bus = (DATA_BUS_OE_O && dev_oe) ? 8'hXX : (DATA_BUS_OE_O ? DATA_BUS_O : dev_d);
  sram_ctl i_dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .REQ_VALID_I(REQ_VALID_I),
    .REQ_READY_O(REQ_READY_O), .REQ_WRITE_I(REQ_WRITE_I), .REQ_ADDR_I(REQ_ADDR_I),
    .REQ_WDATA_I(REQ_WDATA_I), .RSP_VALID_O(RSP_VALID_O), .RSP_RDATA_O(RSP_RDATA_O),
    .RSP_CORRECTED_O(RSP_CORRECTED_O), .SELECT_LOW_ACTIVE_N_O(SELECT_LOW_ACTIVE_N_O),
    .SELECT_HIGH_ACTIVE_O(SELECT_HIGH_ACTIVE_O), .WE_N_O(WE_N_O), .OE_N_O(OE_N_O),
    .ADDR_O(ADDR_O), .DATA_BUS_I(bus), .DATA_BUS_O(DATA_BUS_O),
    .DATA_BUS_OE_O(DATA_BUS_OE_O), .ERR_I(err));
  sram_dev_model i_mem (.clk_i(MCLK_I), .sel_n_i(SELECT_LOW_ACTIVE_N_O),
    .sel_h_i(SELECT_HIGH_ACTIVE_O), .we_n_i(WE_N_O), .oe_n_i(OE_N_O), .addr_i(ADDR_O),
    .bus_i(bus), .flip_i(flip), .d_o(dev_d), .oe_o(dev_oe), .err_o(err));
  task automatic chk(string n, logic [19:0] e, logic [19:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task conclude;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic req(logic w, logic [19:0] a, logic [7:0] d);
    int n;
    n = 0;
    @(negedge MCLK_I);
    while (REQ_READY_O !== 1'b1 && n < 100) begin
      @(negedge MCLK_I);
      n++;
    end
    chk("ready_wait", 0, 20'(n == 100));
    {REQ_WRITE_I, REQ_ADDR_I, REQ_WDATA_I, req_a} = {w, a, d, a};
    REQ_VALID_I = 1'b1;
    @(negedge MCLK_I);
    REQ_VALID_I = 1'b0;
  endtask : req
  task automatic rd(logic [19:0] a, logic [7:0] e, logic c);
    int n;
    req(1'b0, a, 8'h00);
    for (n = 0; n < 40 && RSP_VALID_O !== 1'b1; n++) @(negedge MCLK_I);
    chk("rsp_valid", 1, 20'(RSP_VALID_O));
    chk("rdata", 20'(e), 20'(RSP_RDATA_O));
    chk("corrected", 20'(c), 20'(RSP_CORRECTED_O));
  endtask : rd
  task t_idle;
    chk("sel_idle", 20'h00002, 20'({SELECT_LOW_ACTIVE_N_O, SELECT_HIGH_ACTIVE_O}));
    chk("strobe_idle", 20'h00003, 20'({WE_N_O, OE_N_O}));
    chk("bus_oe_idle", 0, 20'(DATA_BUS_OE_O));
  endtask : t_idle
  task t_rw;
    req(1'b1, 20'hFFFFF, 8'hA5);
    req(1'b1, 20'h00000, 8'h5A);
    rd(20'hFFFFF, 8'hA5, 1'b0);
    req(1'b1, 20'h12345, 8'hFF);
    rd(20'h12345, 8'hFF, 1'b0);
    rd(20'h00000, 8'h5A, 1'b0);
  endtask : t_rw
  task t_corr;
    flip = 1'b1;
    rd(20'hFFFFF, 8'hA5, 1'b1);
    flip = 1'b0;
    rd(20'hFFFFF, 8'hA5, 1'b0);
  endtask : t_corr
  task t_midreset;
    req(1'b1, 20'h00F0F, 8'h3C);
    repeat (6) @(negedge MCLK_I);
    RST_I = 1'b1;
    repeat (5) @(negedge MCLK_I);
    t_idle();
    RST_I = 1'b0;
    rd(20'h00000, 8'h5A, 1'b0);
  endtask : t_midreset
  // ==========================================================
  // Pin watcher: ownership, address and write data stability
  always @(negedge MCLK_I) begin
    if (!RST_I) begin
      chk("bus_owner", 0, 20'(DATA_BUS_OE_O & dev_oe));
      if (sel && !sel_q) chk("addr_at_sel", req_a, ADDR_O);
      if (sel && sel_q) chk("addr_hold", addr_q, ADDR_O);
      if (wr && wr_q) chk("wdata_hold", 20'(wd_q), 20'(DATA_BUS_O));
      if (!wr && wr_q) chk("wdata_end", 20'({1'b1, wd_q}), 20'({DATA_BUS_OE_O, DATA_BUS_O}));
    end
    {sel_q, wr_q, addr_q, wd_q} = {sel, wr, ADDR_O, DATA_BUS_O};
  end
  initial begin
    MCLK_I = 1'b0;
    forever #2.5 MCLK_I = ~MCLK_I;
  end
  initial begin
    #20000;
    failures++;
    conclude();
  end
  initial begin
    {RST_I, REQ_VALID_I, REQ_WRITE_I, REQ_ADDR_I, REQ_WDATA_I, flip, req_a} = 0;
    RST_I = 1'b1;
    repeat (5) @(negedge MCLK_I);
    RST_I = 1'b0;
    t_idle();
    t_rw();
    t_corr();
    t_midreset();
    conclude();
  end
endmodule : test_async_sram_ecc_port
